// *** hw/icg_gpio_port.sv ***
// Indexed-configuration GPIO unit: key-locked index/data port pair and four GPIO pins.
// Assumes host I/O cycles arrive as one-cycle strobes synchronous to clk_sys; pins are synchronous too.
`timescale 1ns/100ps
module icg_gpio_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Host I/O cycles
    input wire icg_pkg::icg_io_req_t io_req,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    // Board pins
    input wire logic [icg_pkg::ICG_PORTS-1:0] gpio_in,
    output icg_pkg::icg_pins_t pins,
    // Status
    output logic cfg_mode_open
);
    import icg_pkg::*;

    icg_mode_t mode_reg, mode_next;
    logic cfg_open_reg;
    logic [7:0] index_reg;
    logic [7:0] dev_sel_reg;
    logic [7:0] pin_mux_reg;
    logic [7:0] activate_reg;
    logic [7:0] dir_reg;
    logic [7:0] data_reg;
    logic [7:0] inv_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    icg_pins_t pins_reg;

    // Decode of host cycles
    wire idx_wr = io_req.wr && io_req.addr == ICG_INDEX_ADDR;
    wire dat_wr = io_req.wr && io_req.addr == ICG_DATA_ADDR;
    wire dat_rd = io_req.rd && io_req.addr == ICG_DATA_ADDR;
    wire key_unlock = idx_wr && io_req.wdata == ICG_UNLOCK_KEY;
    wire key_lock = idx_wr && io_req.wdata == ICG_LOCK_KEY;
    wire is_open = mode_reg == ICG_OPEN;
    wire gpio_sel = dev_sel_reg == ICG_GPIO_DEV;
    wire gpio_act = gpio_sel && activate_reg[0];
    wire gpio_route = (pin_mux_reg & ICG_MUX_GPIO_MASK) == ICG_MUX_GPIO_MASK;
    wire cfg_wr = is_open && dat_wr;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
        hit = idx == target;
    endfunction : hit

    // Register selects; the per-device registers answer only while the GPIO device is selected
    wire sel_dev_sel = hit(index_reg, ICG_IDX_DEV_SEL);
    wire sel_pin_mux = hit(index_reg, ICG_IDX_PIN_MUX);
    wire sel_activate = gpio_sel && hit(index_reg, ICG_IDX_ACTIVATE);
    wire sel_dir = gpio_sel && hit(index_reg, ICG_IDX_DIR);
    wire sel_data = gpio_sel && hit(index_reg, ICG_IDX_DATA);
    wire sel_inv = gpio_sel && hit(index_reg, ICG_IDX_INV);

    // Write enables; data port writes count only in extended configuration mode
    wire wr_index = is_open && idx_wr && !key_lock;
    wire wr_dev_sel = cfg_wr && sel_dev_sel;
    wire wr_pin_mux = cfg_wr && sel_pin_mux;
    wire wr_activate = cfg_wr && sel_activate;
    wire wr_dir = cfg_wr && sel_dir;
    wire wr_inv = cfg_wr && sel_inv;
    wire wr_data = cfg_wr && sel_data;

    // Key sequence
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            ICG_LOCKED: if (idx_wr) mode_next = key_unlock ? ICG_HALF : ICG_LOCKED;
            ICG_HALF: if (idx_wr) mode_next = key_unlock ? ICG_OPEN : ICG_LOCKED;
            ICG_OPEN: if (key_lock) mode_next = ICG_LOCKED;
            default: mode_next = ICG_LOCKED;
        endcase
    end

    // Pin level seen by the data register, after inversion
    wire [ICG_PORTS-1:0] inv_n = inv_reg[ICG_GPIO_LSB +: ICG_PORTS];
    wire [ICG_PORTS-1:0] dir_n = dir_reg[ICG_GPIO_LSB +: ICG_PORTS];
    wire [ICG_PORTS-1:0] dat_n = data_reg[ICG_GPIO_LSB +: ICG_PORTS];
    wire [ICG_PORTS-1:0] pin_seen = gpio_in ^ inv_n;
    wire [ICG_PORTS-1:0] pin_drive = dat_n ^ inv_n;

    // Per-port data bit: inputs follow the pin, outputs take host writes
    wire [ICG_PORTS-1:0] dat_next_n;
    genvar g;
    generate
        for (g = 0; g < ICG_PORTS; g++) begin : g_port
            assign dat_next_n[g] = dir_n[g] ? pin_seen[g]
                                 : (wr_data ? io_req.wdata[ICG_GPIO_LSB + g] : dat_n[g]);
        end
    endgenerate

    // Read mux for the data port; a locked port reads as an idle bus
    wire [7:0] data_view = {dat_next_n, data_reg[ICG_GPIO_LSB-1:0]};
    wire [7:0] rd_mux =
        !is_open ? ICG_READ_IDLE :
        sel_dev_sel ? dev_sel_reg :
        sel_pin_mux ? pin_mux_reg :
        sel_activate ? activate_reg :
        sel_dir ? dir_reg :
        sel_data ? data_view :
        sel_inv ? inv_reg : 8'h00;

    // Pin driver: only outputs of the active, routed device drive; enable is low while driving
    wire pins_on = gpio_act && gpio_route;
    wire [ICG_PORTS-1:0] drv_oe_n;
    wire [ICG_PORTS-1:0] port_level;
    generate
        for (g = 0; g < ICG_PORTS; g++) begin : g_pin
            assign drv_oe_n[g] = !(pins_on && !dir_n[g]);
            assign port_level[g] = drv_oe_n[g] ? gpio_in[g] : pin_drive[g];
        end
    endgenerate
    icg_pins_t pins_next;
    always_comb begin
        pins_next.out = pin_drive;
        pins_next.oe_n = drv_oe_n;
        pins_next.buf_out = ~port_level;
    end

    // Register state resets only with rst; battery-backed retention is the supply's job
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_reg <= ICG_LOCKED;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Status copy of the open state, so the output leaves a flip-flop and not a decoder
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_open_reg <= 1'b0;
        end else begin
            cfg_open_reg <= mode_next == ICG_OPEN;
        end
    end

    // The lock key leaves the index alone; each session selects its register anew anyway
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            index_reg <= ICG_RST_INDEX;
        end else if (wr_index) begin
            index_reg <= io_req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dev_sel_reg <= ICG_RST_DEV_SEL;
        end else if (wr_dev_sel) begin
            dev_sel_reg <= io_req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_mux_reg <= ICG_RST_PIN_MUX;
        end else if (wr_pin_mux) begin
            pin_mux_reg <= io_req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            activate_reg <= ICG_RST_ACTIVATE;
        end else if (wr_activate) begin
            activate_reg <= io_req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dir_reg <= ICG_RST_DIR;
        end else if (wr_dir) begin
            dir_reg <= io_req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            inv_reg <= ICG_RST_INV;
        end else if (wr_inv) begin
            inv_reg <= io_req.wdata;
        end
    end

    // Input bits refresh every cycle, so a read returns the live pin level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_reg <= ICG_RST_DATA;
        end else begin
            if (wr_data) data_reg[ICG_GPIO_LSB-1:0] <= io_req.wdata[ICG_GPIO_LSB-1:0];
            data_reg[ICG_GPIO_LSB +: ICG_PORTS] <= dat_next_n;
        end
    end

    // The answer strobe stands for one cycle; the data behind it holds until the next read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= dat_rd;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= ICG_RST_RDATA;
        end else if (dat_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    // Pins follow the settings one cycle late, which keeps every pin output on a flip-flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins_reg <= '{out: '0, oe_n: '1, buf_out: '1};
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign io_rdata = rdata_reg;
    assign io_rvalid = rvalid_reg;
    assign pins = pins_reg;
    assign cfg_mode_open = cfg_open_reg;
endmodule : icg_gpio_port

// *** hw/icg_pkg.sv ***
// Constants, register map and carrier types of the indexed-config GPIO port.
// Assumes one system clock at 20 MHz and host I/O cycles presented as one-cycle strobes.
// Contract
// - Two successive writes of the unlock key to the index port enter extended configuration mode.
// - In that mode a write to the index port selects a register and the data port then reads or writes it.
// - Writing the lock key to the index port leaves the mode and stops configuration decoding.
// - Writing the GPIO device number to the device select register points the upper registers at GPIO.
// - Writing one to the activation register makes the selected GPIO device operational.
// - Setting the indicated multiplex bits routes the shared pins to GPIO group one, kept by read-modify-write.
// - Only bits 4 to 7 of direction, inversion and data serve GPIO, bit 4 being port one, each independent.
// - An inversion bit of one complements the value between pin and data bit in both directions.
// - A direction bit of one makes a port an input, zero makes it an output driven from the data register.
// - Data bits of outputs read and write; data bits of inputs read the pin and ignore writes.
// - Settings and output states are kept across main and standby power loss while the battery holds.
// - Each buffered digital output presents the complement of its GPIO port level.
package icg_pkg;
    localparam logic [15:0] ICG_INDEX_ADDR = 16'h002e;
    localparam logic [15:0] ICG_DATA_ADDR = 16'h002f;
    localparam logic [7:0] ICG_UNLOCK_KEY = 8'h87;
    localparam logic [7:0] ICG_LOCK_KEY = 8'haa;
    localparam logic [7:0] ICG_IDX_DEV_SEL = 8'h07;
    localparam logic [7:0] ICG_IDX_PIN_MUX = 8'h2a;
    localparam logic [7:0] ICG_IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] ICG_IDX_DIR = 8'hf0;
    localparam logic [7:0] ICG_IDX_DATA = 8'hf1;
    localparam logic [7:0] ICG_IDX_INV = 8'hf2;
    localparam logic [7:0] ICG_GPIO_DEV = 8'h07;
    localparam logic [7:0] ICG_MUX_GPIO_MASK = 8'h84;
    localparam int ICG_GPIO_LSB = 4;
    localparam int ICG_PORTS = 4;
    localparam logic [7:0] ICG_RST_DEV_SEL = 8'h00;
    localparam logic [7:0] ICG_RST_PIN_MUX = 8'h00;
    localparam logic [7:0] ICG_RST_ACTIVATE = 8'h00;
    localparam logic [7:0] ICG_RST_DIR = 8'hff;
    localparam logic [7:0] ICG_RST_DATA = 8'h00;
    localparam logic [7:0] ICG_RST_INV = 8'h00;
    localparam logic [7:0] ICG_RST_INDEX = 8'h00;
    localparam logic [7:0] ICG_RST_RDATA = 8'h00;
    localparam logic [7:0] ICG_READ_IDLE = 8'hff;

    typedef enum logic [1:0] {
        ICG_LOCKED = 2'b00,
        ICG_HALF = 2'b01,
        ICG_OPEN = 2'b11
    } icg_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } icg_io_req_t;

    typedef struct packed {
        logic [ICG_PORTS-1:0] out;
        logic [ICG_PORTS-1:0] oe_n;
        logic [ICG_PORTS-1:0] buf_out;
    } icg_pins_t;
endpackage : icg_pkg

// *** verification/icg_gpio_port_sva.sv ***
// Checker on the host strobes, read answer, mode flag and pin outputs.
// Assumes bind into icg_gpio_port; one clock, synchronous reset.
`timescale 1ns/100ps
module icg_gpio_port_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Host and pins
    input wire icg_pkg::icg_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic [3:0] gpio_in,
    input wire icg_pkg::icg_pins_t pins,
    input wire logic cfg_mode_open
);
    import icg_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire rd_data = io_req.rd && io_req.addr == ICG_DATA_ADDR;
    wire wr_idx = io_req.wr && io_req.addr == ICG_INDEX_ADDR;
    wire key_wr = wr_idx && io_req.wdata == ICG_UNLOCK_KEY;
    rd_answer_a: assert property (rd_data |=> io_rvalid) else $error("data read unanswered");
    rvalid_cause_a: assert property (io_rvalid |-> $past(rd_data)) else $error("answer without read");
    unlock_pair_a: assert property (key_wr && !cfg_mode_open ##1 !io_req.wr ##1 key_wr |=> cfg_mode_open)
        else $error("key pair did not open");
    lock_key_a: assert property (wr_idx && io_req.wdata == ICG_LOCK_KEY && cfg_mode_open |=> !cfg_mode_open)
        else $error("lock key ignored");
    stay_locked_a: assert property (!cfg_mode_open && !key_wr |=> !cfg_mode_open) else $error("opened without key");
    locked_read_a: assert property (rd_data && !cfg_mode_open |=> io_rdata == ICG_READ_IDLE)
        else $error("locked read not idle");
    buf_level_a: assert property (((pins.buf_out ^ ~pins.out) & ~pins.oe_n) == 4'h0) else $error("buffer not inverse");
    // Undriven ports follow their pin, so only the driven bits must hold
    locked_pins_a: assert property (!cfg_mode_open && io_req.wr |=>
        $stable(pins.oe_n) && $stable(pins.out & ~pins.oe_n)) else $error("locked write moved pins");
endmodule : icg_gpio_port_sva
bind icg_gpio_port icg_gpio_port_sva u_sva (.clk_sys(clk_sys), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .gpio_in(gpio_in), .pins(pins), .cfg_mode_open(cfg_mode_open));

// *** verification/icg_gpio_port_tb.sv ***
// Self-checking bench for the indexed-config GPIO port.
// Assumes the host model makes every host cycle and the checker is bound.
`timescale 1ns/100ps
module icg_gpio_port_tb;
    import icg_pkg::*;
    logic clk_sys;
    logic rst;
    logic [3:0] gpio_in;
    icg_io_req_t io_req;
    logic [7:0] io_rdata;
    logic io_rvalid;
    icg_pins_t pins;
    logic cfg_mode_open;
    int mismatches;
    int compares;
    logic [15:0] tab [5] = '{16'h2a00, 16'h3000, 16'hf0ff, 16'hf100, 16'hf200};
    icg_gpio_port u_dut (.clk_sys(clk_sys), .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .gpio_in(gpio_in), .pins(pins), .cfg_mode_open(cfg_mode_open));
    icg_host_model u_host (.clk_sys(clk_sys), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        gpio_in = 4'h0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        u_host.cfg_upd(ICG_IDX_DEV_SEL, 8'h00, 8'h00, 1'b0);
        chk(u_host.rd_val, 8'h00);
        u_host.cfg_upd(ICG_IDX_ACTIVATE, 8'h00, 8'h00, 1'b0);
        chk(u_host.rd_val, 8'h00);
        u_host.cfg_upd(ICG_IDX_DEV_SEL, 8'h00, ICG_GPIO_DEV, 1'b1);
        for (int i = 0; i < 5; i++) begin
            u_host.cfg_upd(tab[i][15:8], 8'h00, 8'h00, 1'b0);
            chk(u_host.rd_val, tab[i][7:0]);
        end
        $display("test reset_values done");
        u_host.io_wr(ICG_INDEX_ADDR, ICG_IDX_DEV_SEL);
        u_host.io_wr(ICG_DATA_ADDR, 8'hff);
        u_host.io_rd(ICG_DATA_ADDR);
        chk(u_host.rd_val, ICG_READ_IDLE);
        u_host.cfg_upd(ICG_IDX_DEV_SEL, 8'h00, 8'h00, 1'b0);
        chk(u_host.rd_val, ICG_GPIO_DEV);
        u_host.cfg_upd(ICG_IDX_INV, 8'h00, 8'h00, 1'b0);
        chk(u_host.rd_val, ICG_RST_INV);
        $display("test locked_port done");
        gpio_in <= 4'b0010;
        u_host.cfg_upd(ICG_IDX_PIN_MUX, 8'hff, ICG_MUX_GPIO_MASK, 1'b1);
        u_host.cfg_upd(ICG_IDX_ACTIVATE, 8'h00, 8'h01, 1'b1);
        u_host.cfg_upd(ICG_IDX_DIR, 8'h0f, 8'he0, 1'b1);
        u_host.cfg_upd(ICG_IDX_INV, 8'h0f, 8'h20, 1'b1);
        u_host.cfg_upd(ICG_IDX_DATA, 8'h0f, 8'h50, 1'b1);
        u_host.cfg_upd(ICG_IDX_DATA, 8'h00, 8'h00, 1'b0);
        chk(u_host.rd_val, 8'h10);
        chk({pins.oe_n, pins.buf_out}, 8'hec);
        u_host.cfg_upd(ICG_IDX_INV, 8'h0f, 8'h30, 1'b1);
        u_host.cfg_upd(ICG_IDX_DATA, 8'h00, 8'h00, 1'b0);
        chk(u_host.rd_val, 8'h10);
        chk({pins.out[0], 3'h0, pins.buf_out}, 8'h0d);
        u_host.cfg_upd(ICG_IDX_DEV_SEL, 8'h00, 8'h00, 1'b1);
        u_host.cfg_upd(ICG_IDX_ACTIVATE, 8'h00, 8'h00, 1'b0);
        chk(u_host.rd_val, 8'h00);
        chk({4'h0, pins.oe_n}, 8'h0f);
        $display("test gpio_ports done");
        summarize();
    end
endmodule : icg_gpio_port_tb

// *** verification/icg_host_model.sv ***
// Host model issuing one-cycle I/O strobes to the index and data ports.
// Assumes the port samples strobes on the rising edge of clk_sys.
`timescale 1ns/100ps
module icg_host_model (
    // Clock
    input wire logic clk_sys,
    // Host I/O cycles
    output icg_pkg::icg_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid
);
    import icg_pkg::*;
    logic [7:0] rd_val;
    initial io_req = '0;
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        // Idle bus shows the inverse, so a stale value is never mistaken for a cycle
        io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : io_wr
    task automatic io_rd(input logic [15:0] a);
        @(posedge clk_sys);
        io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        @(negedge clk_sys);
        rd_val = (io_rvalid === 1'b1) ? io_rdata : 8'hxx;
    endtask : io_rd
    // Whole sequence per register; bits in keep are kept by read-modify-write, bits in set are set, all other bits are cleared
    task automatic cfg_upd(input logic [7:0] idx, input logic [7:0] keep, input logic [7:0] set, input logic wr);
        io_wr(ICG_INDEX_ADDR, ICG_UNLOCK_KEY);
        io_wr(ICG_INDEX_ADDR, ICG_UNLOCK_KEY);
        io_wr(ICG_INDEX_ADDR, idx);
        io_rd(ICG_DATA_ADDR);
        if (wr)
            io_wr(ICG_DATA_ADDR, (rd_val & keep) | set);
        io_wr(ICG_INDEX_ADDR, ICG_LOCK_KEY);
    endtask : cfg_upd
endmodule : icg_host_model
